// ### verilog/flash_cfg_pkg.sv
/*
  Shared constants and types for the protocol-select and status block of a
  serial flash. Assumes a single 200 MHz core clock samples the serial pins.
*/
package flash_cfg_pkg;
  // ******************************************************************
  // timing
  // ******************************************************************
  localparam int CLOCK_MHZ = 200;
  localparam int WRITE_TIME_NS = 2000;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS * CLOCK_MHZ + 999) / 1000;

  // ******************************************************************
  // command codes, one byte each
  // ******************************************************************
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0] CMD_WRITE_VOLATILE_CFG = 8'h81;
  localparam logic [7:0] CMD_WRITE_ENHANCED_VOLATILE_CFG = 8'h61;
  localparam logic [7:0] CMD_WRITE_NONVOLATILE_CFG = 8'hB1;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] CMD_WHOLE_ARRAY_ERASE = 8'hC7;

  // ******************************************************************
  // field positions and reset values
  // ******************************************************************
  localparam int EVCFG_DUAL_BIT = 6;
  localparam int EVCFG_QUAD_BIT = 7;
  localparam int NVCFG_DUAL_BIT = 2;
  localparam int NVCFG_QUAD_BIT = 3;
  localparam logic [15:0] NVCFG_RESET = 16'hFFFF;
  localparam logic [7:0] VCFG_RESET = 8'hFF;
  localparam logic [7:0] EVCFG_RESET = 8'hFF;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int SECTOR_MSB = 21;
  localparam int SECTOR_LSB = 16;

  typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} proto_t;

  // status register layout, bit 7 down to bit 0
  typedef struct packed {
    logic writeDisable;
    logic reserved;
    logic bottom;
    logic [2:0] blockProtect;
    logic writeEnable;
    logic writeBusy;
  } status_t;
endpackage

// ### verilog/spi_protocol_select_and_status.sv
/*
  Serial front end with protocol selection, working configuration and the
  status register. Assumes serial clock, select and lanes arrive from pins
  asynchronous to clock; the serial clock is well below clock/4.
*/
`timescale 1ns/1ps
module spi_protocol_select_and_status
  import flash_cfg_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic serialClk,
  input wire logic chipSel_b,
  input wire logic [3:0] dqIn,
  output logic [3:0] dqOut,
  output logic [3:0] dqOe,
  input wire logic writeProt_b,
  input wire logic vppHigh,
  input wire logic rescueReq,
  output status_t statusFlags,
  output proto_t protocol,
  output logic [15:0] nvCfg,
  output logic [7:0] volatileCfg,
  output logic [7:0] enhancedCfg
);
  // ******************************************************************
  // pin synchronisers
  // ******************************************************************
  logic [8:0] syncA_q;
  logic [8:0] syncB_q;
  logic [8:0] syncPrev_q;
  // first stage is read only by the second
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      syncA_q <= 9'h1_22;
      syncB_q <= 9'h1_22;
      syncPrev_q <= 9'h1_22;
    end else begin
      syncA_q <= {rescueReq, vppHigh, writeProt_b, chipSel_b, serialClk, dqIn};
      syncB_q <= syncA_q;
      syncPrev_q <= syncB_q;
    end
  end

  logic [3:0] dqS;
  logic sclkRise, sclkFall, csLow, csRise, wpHigh, vppS, rescueRise;
  assign dqS = syncB_q[3:0];
  assign sclkRise = syncB_q[4] & ~syncPrev_q[4];
  assign sclkFall = ~syncB_q[4] & syncPrev_q[4];
  assign csLow = ~syncB_q[5];
  assign csRise = syncB_q[5] & ~syncPrev_q[5];
  assign wpHigh = syncB_q[6];
  assign vppS = syncB_q[7];
  assign rescueRise = syncB_q[8] & ~syncPrev_q[8];

  // ******************************************************************
  // state
  // ******************************************************************
  typedef enum logic [1:0] {ST_BOOT, ST_CMD, ST_DATA, ST_DROP} phase_t;
  phase_t phase_q, phase_d;
  proto_t proto_q, proto_d;
  status_t status_q, status_d;
  logic [15:0] nvCfg_q = NVCFG_RESET, nvCfg_d; // factory-erased content, kept over resets
  logic [7:0] vCfg_q, vCfg_d, evCfg_q, evCfg_d;
  logic [7:0] cmd_q, cmd_d, shift_q, shift_d, outShift_q, outShift_d;
  logic [23:0] args_q, args_d;
  logic [2:0] bitCnt_q, bitCnt_d, outCnt_q, outCnt_d;
  logic [1:0] argBytes_q, argBytes_d;
  logic reading_q, reading_d, prog_q, prog_d;
  logic [31:0] busyCnt_q, busyCnt_d;
  logic [3:0] dqOut_q, dqOut_d, dqOe_q, dqOe_d;

  // ******************************************************************
  // helpers
  // ******************************************************************
  proto_t laneMode;
  logic [2:0] laneWidth;
  logic [7:0] shiftIn;
  logic [6:0] protSectors;
  logic [5:0] sector;
  logic sectorProt, statusLocked, wholeBytes;
  status_t statusView;

  // quad falls back to one lane while a Vpp program or erase runs
  always_comb begin
    laneMode = proto_q;
    if (proto_q == PROTO_QUAD && vppS && status_q.writeBusy && prog_q) begin
      laneMode = PROTO_EXT;
    end
  end

  // command, address and data share the lane count of the mode
  always_comb begin
    case (laneMode)
      PROTO_DUAL: begin
        laneWidth = 3'd2;
        shiftIn = {shift_q[5:0], dqS[1:0]};
      end
      PROTO_QUAD: begin
        laneWidth = 3'd4;
        shiftIn = {shift_q[3:0], dqS[3:0]};
      end
      default: begin
        laneWidth = 3'd1;
        shiftIn = {shift_q[6:0], dqS[0]};
      end
    endcase
  end

  // protected sector count doubles per block-protect step; 7 covers all
  always_comb begin
    sector = args_q[SECTOR_MSB:SECTOR_LSB];
    if (status_q.blockProtect == 3'd0) begin
      protSectors = 7'd0;
    end else if (status_q.blockProtect == 3'd7) begin
      protSectors = 7'd64;
    end else begin
      protSectors = 7'(7'd1 << (status_q.blockProtect - 3'd1));
    end
    if (status_q.bottom) begin
      sectorProt = {1'b0, sector} < protSectors;
    end else begin
      sectorProt = {1'b0, sector} >= (7'd64 - protSectors);
    end
    if (protSectors == 7'd0) begin
      sectorProt = 1'b0;
    end
  end

  assign statusLocked = status_q.writeDisable & ~wpHigh;
  assign wholeBytes = (bitCnt_q == 3'd0);
  always_comb begin
    statusView = status_q;
    statusView.reserved = 1'b0;
  end

  // ******************************************************************
  // command engine
  // ******************************************************************
  always_comb begin
    phase_d = phase_q;
    proto_d = proto_q;
    status_d = status_q;
    nvCfg_d = nvCfg_q;
    vCfg_d = vCfg_q;
    evCfg_d = evCfg_q;
    cmd_d = cmd_q;
    shift_d = shift_q;
    args_d = args_q;
    bitCnt_d = bitCnt_q;
    argBytes_d = argBytes_q;
    reading_d = reading_q;
    prog_d = prog_q;
    busyCnt_d = busyCnt_q;
    outShift_d = outShift_q;
    outCnt_d = outCnt_q;
    dqOut_d = dqOut_q;
    dqOe_d = dqOe_q;
    // internal write timer; the latch drops when the cycle ends
    if (status_q.writeBusy) begin
      if (busyCnt_q <= 32'd1) begin
        status_d.writeBusy = 1'b0;
        status_d.writeEnable = 1'b0;
        prog_d = 1'b0;
      end else begin
        busyCnt_d = busyCnt_q - 32'd1;
      end
    end
    case (phase_q)
      // working mode comes from nonvolatile settings, volatile copies from their reset values; quad wins over dual
      ST_BOOT: begin
        if (!nvCfg_q[NVCFG_QUAD_BIT]) begin
          proto_d = PROTO_QUAD;
        end else if (!nvCfg_q[NVCFG_DUAL_BIT]) begin
          proto_d = PROTO_DUAL;
        end else begin
          proto_d = PROTO_EXT;
        end
        vCfg_d = VCFG_RESET;
        evCfg_d = EVCFG_RESET;
        phase_d = ST_CMD;
      end
      ST_CMD, ST_DATA, ST_DROP: begin
        if (csLow && sclkRise && !reading_q) begin
          shift_d = shiftIn;
          bitCnt_d = 3'(bitCnt_q + laneWidth);
          if (3'(bitCnt_q + laneWidth) == 3'd0) begin
            if (phase_q == ST_CMD) begin
              cmd_d = shiftIn;
              phase_d = ST_DATA;
              reading_d = (shiftIn == CMD_READ_STATUS);
              outCnt_d = 3'd0;
            end else if (phase_q == ST_DATA && argBytes_q != 2'd3) begin
              args_d = {args_q[15:0], shiftIn};
              argBytes_d = argBytes_q + 2'd1;
            end
          end
        end
        // read status streams MSB first, reloaded every byte
        if (csLow && sclkFall && reading_q) begin
          dqOe_d = (laneMode == PROTO_QUAD) ? 4'hF :
                   (laneMode == PROTO_DUAL) ? 4'h3 : 4'h2;
          if (outCnt_q == 3'd0) begin
            outShift_d = 8'(statusView << laneWidth);
            outCnt_d = 3'(3'd0 - laneWidth);
            dqOut_d = (laneMode == PROTO_QUAD) ? statusView[7:4] :
                      (laneMode == PROTO_DUAL) ? {2'b00, statusView[7:6]} :
                      {2'b00, statusView[7], 1'b0};
          end else begin
            outShift_d = 8'(outShift_q << laneWidth);
            outCnt_d = 3'(outCnt_q - laneWidth);
            dqOut_d = (laneMode == PROTO_QUAD) ? outShift_q[7:4] :
                      (laneMode == PROTO_DUAL) ? {2'b00, outShift_q[7:6]} :
                      {2'b00, outShift_q[7], 1'b0};
          end
        end
        // commands act when select rises, and only on whole bytes
        if (csRise) begin
          if (phase_q == ST_DATA && wholeBytes && !status_q.writeBusy) begin
            if (cmd_q == CMD_WRITE_ENABLE) begin
              status_d.writeEnable = 1'b1;
            end else if (cmd_q == CMD_WRITE_STATUS) begin
              if (status_q.writeEnable && !statusLocked && argBytes_q != 2'd0) begin
                status_d.writeDisable = args_q[7];
                status_d.bottom = args_q[5];
                status_d.blockProtect = args_q[4:2];
                status_d.writeBusy = 1'b1;
                busyCnt_d = WRITE_CYCLES_P;
              end
            end else if (cmd_q == CMD_WRITE_NONVOLATILE_CFG) begin
              if (status_q.writeEnable && argBytes_q == 2'd2) begin
                nvCfg_d = {args_q[7:0], args_q[15:8]};
                status_d.writeBusy = 1'b1;
                busyCnt_d = WRITE_CYCLES_P;
              end
            end else if (cmd_q == CMD_WRITE_VOLATILE_CFG) begin
              if (status_q.writeEnable && argBytes_q != 2'd0) begin
                vCfg_d = args_q[7:0];
                status_d.writeEnable = 1'b0;
              end
            end else if (cmd_q == CMD_WRITE_ENHANCED_VOLATILE_CFG) begin
              if (status_q.writeEnable && argBytes_q != 2'd0) begin
                evCfg_d = args_q[7:0];
                status_d.writeEnable = 1'b0;
                if (!args_q[EVCFG_QUAD_BIT]) begin
                  proto_d = PROTO_QUAD;
                end else if (!args_q[EVCFG_DUAL_BIT]) begin
                  proto_d = PROTO_DUAL;
                end else begin
                  proto_d = PROTO_EXT;
                end
              end
            end else if (cmd_q == CMD_PAGE_PROGRAM || cmd_q == CMD_SECTOR_ERASE) begin
              if (status_q.writeEnable && argBytes_q == 2'd3 && !sectorProt) begin
                status_d.writeBusy = 1'b1;
                prog_d = 1'b1;
                busyCnt_d = WRITE_CYCLES_P;
              end
            end else if (cmd_q == CMD_WHOLE_ARRAY_ERASE) begin
              if (status_q.writeEnable && status_q.blockProtect == 3'd0) begin
                status_d.writeBusy = 1'b1;
                prog_d = 1'b1;
                busyCnt_d = WRITE_CYCLES_P;
              end
            end
          end
          phase_d = ST_CMD;
          bitCnt_d = 3'd0;
          argBytes_d = 2'd0;
          args_d = 24'h00_0000;
          reading_d = 1'b0;
          dqOe_d = 4'h0;
          dqOut_d = 4'h0;
        end
        // rescue returns to the default protocol without power cycling
        if (rescueRise) begin
          proto_d = PROTO_EXT;
          evCfg_d = EVCFG_RESET;
        end
      end
      default: phase_d = ST_CMD;
    endcase
  end

  // nonvolatile copy has no reset, so every reboot can load the mode from it
  always_ff @(posedge clock) nvCfg_q <= nvCfg_d;
  // status clears and the volatile copies load all ones at reset; boot then reloads the working mode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= ST_BOOT;
      proto_q <= PROTO_EXT;
      status_q <= STATUS_RESET;
      vCfg_q <= VCFG_RESET;
      evCfg_q <= EVCFG_RESET;
      cmd_q <= 8'h00;
      shift_q <= 8'h00;
      args_q <= 24'h00_0000;
      bitCnt_q <= 3'd0;
      argBytes_q <= 2'd0;
      reading_q <= 1'b0;
      prog_q <= 1'b0;
      busyCnt_q <= 32'h0000_0000;
      outShift_q <= 8'h00;
      outCnt_q <= 3'd0;
      dqOut_q <= 4'h0;
      dqOe_q <= 4'h0;
    end else begin
      phase_q <= phase_d;
      proto_q <= proto_d;
      status_q <= status_d;
      vCfg_q <= vCfg_d;
      evCfg_q <= evCfg_d;
      cmd_q <= cmd_d;
      shift_q <= shift_d;
      args_q <= args_d;
      bitCnt_q <= bitCnt_d;
      argBytes_q <= argBytes_d;
      reading_q <= reading_d;
      prog_q <= prog_d;
      busyCnt_q <= busyCnt_d;
      outShift_q <= outShift_d;
      outCnt_q <= outCnt_d;
      dqOut_q <= dqOut_d;
      dqOe_q <= dqOe_d;
    end
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  assign dqOut = dqOut_q;
  assign dqOe = dqOe_q;
  assign statusFlags = statusView;
  assign protocol = laneMode;
  assign nvCfg = nvCfg_q;
  assign volatileCfg = vCfg_q;
  assign enhancedCfg = evCfg_q;
endmodule

// ### tb/spi_protocol_select_and_status_props.sv
/*
  Checker for the protocol-select and status block: port-level properties.
  Assumes it is bound onto the design top and sees only its ports.
*/
`timescale 1ns/1ps
module spi_protocol_select_and_status_props
  import flash_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic chipSel_b,
  input wire logic writeProt_b,
  input wire logic [3:0] dqOe,
  input wire logic [15:0] nvCfg,
  input status_t statusFlags,
  input proto_t protocol
);
  // ******************************************************************
  // properties
  // ******************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_resv; statusFlags.reserved == 1'b0; endproperty
  a_resv: assert property (p_resv)
    else $error("reserved status bit set");
  // boot lands in the mode the nonvolatile copy asks for, quad first, volatile bits clear
  property p_boot;
    $rose(rst_b) |-> ##2 (statusFlags == 8'h00 && protocol == (!nvCfg[NVCFG_QUAD_BIT] ?
      PROTO_QUAD : (!nvCfg[NVCFG_DUAL_BIT] ? PROTO_DUAL : PROTO_EXT)));
  endproperty
  a_boot: assert property (p_boot)
    else $error("bad state after reset");
  property p_wip; $rose(statusFlags.writeBusy) |-> statusFlags.writeBusy[*8]; endproperty
  a_wip: assert property (p_wip)
    else $error("busy dropped early");
  property p_done; $fell(statusFlags.writeBusy) |-> !statusFlags.writeEnable; endproperty
  a_done: assert property (p_done)
    else $error("latch left set after cycle");
  property p_wel; $rose(statusFlags.writeBusy) |-> $past(statusFlags.writeEnable); endproperty
  a_wel: assert property (p_wel)
    else $error("cycle started without latch");
  property p_hold; statusFlags.writeBusy |-> statusFlags.writeEnable; endproperty
  a_hold: assert property (p_hold)
    else $error("latch cleared while busy");
  // three cycles of pin history so the synchroniser has caught up
  property p_lock;
    statusFlags.writeDisable && !writeProt_b && !$past(writeProt_b, 3)
      |=> $stable(statusFlags[7:2]);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked status changed");
  property p_oe; chipSel_b && $past(chipSel_b, 3) |-> dqOe == 4'h0; endproperty
  a_oe: assert property (p_oe)
    else $error("lanes driven while deselected");

  c_busy: cover property ($rose(statusFlags.writeBusy));
  c_quad: cover property (protocol == PROTO_QUAD);
  c_dual: cover property (protocol == PROTO_DUAL);
  c_lock: cover property (statusFlags.writeDisable && !writeProt_b);
endmodule

bind spi_protocol_select_and_status spi_protocol_select_and_status_props u_props (
  .clock(clock), .rst_b(rst_b), .chipSel_b(chipSel_b), .writeProt_b(writeProt_b),
  .dqOe(dqOe), .nvCfg(nvCfg), .statusFlags(statusFlags), .protocol(protocol));

// ### tb/flash_host_model.sv
/*
  Host model driving the serial pins of the block.
  Assumes mode 0: serial clock parked low, data taken on the rising edge.
*/
`timescale 1ns/1ps
module flash_host_model (
  output logic serialClk,
  output logic chipSel_b,
  output logic [3:0] dqIn,
  input wire logic [3:0] dqOut
);
  // ******************************************************************
  // frame engine
  // ******************************************************************
  initial begin
    serialClk = 1'b0;
    chipSel_b = 1'b1;
    dqIn = 4'h5;
  end

  // msb first, w lanes per rising edge; clock stands still between frames
  task automatic frame(input logic [31:0] d, input int n, input int w, input bit rd,
    output logic [7:0] v);
    v = 8'h00;
    chipSel_b = 1'b0;
    for (int i = 0; i < n; i += w) begin
      dqIn = 4'(d[31:28] >> (4 - w));
      d = d << w;
      #24 serialClk = 1'b1;
      #24 serialClk = 1'b0;
    end
    // status comes back one bit per fall, taken at the next rise
    for (int i = 0; rd && i < 8; i++) begin
      #24 serialClk = 1'b1;
      v = {v[6:0], dqOut[1]};
      #24 serialClk = 1'b0;
    end
    #24 chipSel_b = 1'b1;
    dqIn = ~dqIn; // released lanes must not look like held data
  endtask
endmodule

// ### tb/test_spi_protocol_select_and_status.sv
/*
  Self-checking bench for the protocol-select and status block.
  Assumes the host model owns the serial pins; the bench drives the rest.
*/
`timescale 1ns/1ps
module test_spi_protocol_select_and_status
  import flash_cfg_pkg::*;
;
  // ******************************************************************
  // clock, pins and bookkeeping
  // ******************************************************************
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic writeProt_b = 1'b1;
  logic vppHigh = 1'b0;
  logic rescueReq = 1'b0;
  logic serialClk, chipSel_b;
  logic [3:0] dqIn, dqOut, dqOe;
  logic [15:0] nvCfg;
  logic [7:0] volatileCfg, enhancedCfg, v, r;
  logic [9:0] e;
  status_t statusFlags;
  proto_t protocol;
  int n_errors = 0;
  int total_checks = 0;
  int lanes = 1;
  integer seed = 32'h1953eb65;
  logic [9:0] expq[$];
  event look;

  always #2.5 clock = ~clock;

  spi_protocol_select_and_status #(.WRITE_CYCLES_P(10)) dut (
    .clock(clock), .rst_b(rst_b), .serialClk(serialClk), .chipSel_b(chipSel_b),
    .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .writeProt_b(writeProt_b),
    .vppHigh(vppHigh), .rescueReq(rescueReq), .statusFlags(statusFlags),
    .protocol(protocol), .nvCfg(nvCfg), .volatileCfg(volatileCfg),
    .enhancedCfg(enhancedCfg));

  flash_host_model host (.serialClk(serialClk), .chipSel_b(chipSel_b), .dqIn(dqIn),
    .dqOut(dqOut));

  // ******************************************************************
  // tasks
  // ******************************************************************
  // six clocks covers the sync and act latency after select rises
  task automatic cmd(input logic [31:0] d, input int n);
    host.frame(d, n, lanes, 1'b0, v);
    repeat (6) @(posedge clock);
  endtask

  task automatic ws(input logic [7:0] d, input logic [7:0] c);
    cmd({CMD_WRITE_ENABLE, 24'h0}, 8);
    cmd({c, d, 16'h0}, 16);
  endtask

  // bounded wait for ready, then hand the expectation to the monitor
  task automatic ex(input logic [7:0] s, input proto_t p, input bit w);
    for (int k = 0; w && statusFlags.writeBusy !== 1'b0 && k < 40; k++) @(posedge clock);
    #1 expq.push_back({s, p});
    ->look;
  endtask

  // direct look at a configuration copy; the flags monitor does not carry these
  task automatic cfg_chk(input logic [15:0] got, input logic [15:0] want);
    total_checks++;
    if (got !== want) begin
      n_errors++;
      $display("mismatch at %0t: cfg %h want %h", $time, got, want);
    end
  endtask

  task automatic pulse_in(ref logic x);
    @(posedge clock);
    #1 x = ~x;
    repeat (2) @(posedge clock);
    #1 x = ~x;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // monitor: oldest note against what the outputs show now
  always @(look) begin
    e = expq.pop_front();
    total_checks++;
    if ({statusFlags, protocol} !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, {statusFlags, protocol}, e);
    end
  end

  // frames take about a microsecond each; allow generous slack
  initial begin
    #300000;
    n_errors++;
    complete_run();
  end

  // ******************************************************************
  // scenarios
  // ******************************************************************
  initial begin
    repeat (8) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (6) @(posedge clock);
    ex(8'h00, PROTO_EXT, 1);
    cmd({CMD_WRITE_STATUS, 8'h1C, 16'h0}, 16);
    ex(8'h00, PROTO_EXT, 1);
    for (int i = 0; i < 4; i++) begin
      r = 8'($random(seed));
      ws({1'b0, r[6:0]}, CMD_WRITE_STATUS);
      ex({2'b00, r[5:2], 2'b11}, PROTO_EXT, 0);
      ex({2'b00, r[5:2], 2'b00}, PROTO_EXT, 1);
    end
    cmd({CMD_WRITE_ENABLE, 24'h0}, 8);
    cmd({CMD_WRITE_STATUS, 8'h04, 16'h0}, 15);
    ex({2'b00, r[5:2], 2'b10}, PROTO_EXT, 1);
    cmd({CMD_WRITE_STATUS, 8'h04, 16'h0}, 16);
    ws(8'h00, CMD_WHOLE_ARRAY_ERASE);
    ex(8'h06, PROTO_EXT, 1);
    cmd({CMD_WRITE_STATUS, 8'h00, 16'h0}, 16);
    ws(8'h00, CMD_WHOLE_ARRAY_ERASE);
    ex(8'h03, PROTO_EXT, 0);
    ex(8'h00, PROTO_EXT, 1);
    $display("test status and protection done");
    ws(8'h80, CMD_WRITE_STATUS);
    ex(8'h80, PROTO_EXT, 1);
    host.frame({CMD_READ_STATUS, 24'h0}, 8, 1, 1'b1, v);
    total_checks++;
    if (v !== 8'h80) begin
      n_errors++;
      $display("mismatch at %0t: read status %h", $time, v);
    end
    repeat (6) @(posedge clock);
    #1 writeProt_b = 1'b0;
    ws(8'h1C, CMD_WRITE_STATUS);
    ex(8'h82, PROTO_EXT, 1);
    @(posedge clock);
    #1 writeProt_b = 1'b1;
    repeat (4) @(posedge clock);
    cmd({CMD_WRITE_STATUS, 8'h00, 16'h0}, 16);
    ex(8'h00, PROTO_EXT, 1);
    $display("test lock done");
    ws(8'hA5, CMD_WRITE_VOLATILE_CFG);
    ex(8'h00, PROTO_EXT, 1);
    cfg_chk(volatileCfg, 8'hA5);
    ws(8'h7F, CMD_WRITE_ENHANCED_VOLATILE_CFG);
    ex(8'h00, PROTO_QUAD, 1);
    cfg_chk(enhancedCfg, 8'h7F);
    lanes = 4;
    ws(8'hBF, CMD_WRITE_ENHANCED_VOLATILE_CFG);
    ex(8'h00, PROTO_DUAL, 1);
    lanes = 2;
    pulse_in(rescueReq);
    repeat (4) @(posedge clock);
    ex(8'h00, PROTO_EXT, 1);
    cfg_chk(enhancedCfg, EVCFG_RESET);
    lanes = 1;
    ws(8'h7F, CMD_WRITE_ENHANCED_VOLATILE_CFG);
    lanes = 4;
    ws(8'hFF, CMD_WRITE_ENHANCED_VOLATILE_CFG);
    ex(8'h00, PROTO_EXT, 1);
    lanes = 1;
    ws(8'h7F, CMD_WRITE_ENHANCED_VOLATILE_CFG);
    lanes = 4;
    @(posedge clock);
    #1 vppHigh = 1'b1;
    cmd({CMD_WRITE_ENABLE, 24'h0}, 8);
    cmd({CMD_SECTOR_ERASE, 24'h0}, 32);
    ex(8'h03, PROTO_EXT, 0);
    @(posedge clock);
    #1 vppHigh = 1'b0;
    ex(8'h00, PROTO_QUAD, 1);
    pulse_in(rst_b);
    lanes = 1;
    repeat (4) @(posedge clock);
    ex(8'h00, PROTO_EXT, 1);
    cfg_chk(volatileCfg, VCFG_RESET);
    $display("test protocol select done");
    cmd({CMD_WRITE_ENABLE, 24'h0}, 8);
    cmd({CMD_WRITE_NONVOLATILE_CFG, 8'hF3, 8'hFF, 8'h00}, 24);
    ex(8'h00, PROTO_EXT, 1);
    cfg_chk(nvCfg, 16'hFFF3);
    pulse_in(rst_b);
    lanes = 4;
    repeat (4) @(posedge clock);
    ex(8'h00, PROTO_QUAD, 1);
    cmd({CMD_WRITE_ENABLE, 24'h0}, 8);
    cmd({CMD_WRITE_NONVOLATILE_CFG, 8'hFB, 8'hFF, 8'h00}, 24);
    ex(8'h00, PROTO_QUAD, 1);
    pulse_in(rst_b);
    lanes = 2;
    repeat (4) @(posedge clock);
    ex(8'h00, PROTO_DUAL, 1);
    cmd({CMD_WRITE_ENABLE, 24'h0}, 8);
    cmd({CMD_WRITE_NONVOLATILE_CFG, 8'hFF, 8'hFF, 8'h00}, 24);
    ex(8'h00, PROTO_DUAL, 1);
    cfg_chk(nvCfg, 16'hFFFF);
    pulse_in(rst_b);
    lanes = 1;
    repeat (4) @(posedge clock);
    ex(8'h00, PROTO_EXT, 1);
    $display("test nonvolatile boot done");
    complete_run();
  end
endmodule
